//--- src/mmt_defs.svh
`ifndef MMT_DEFS_SVH
`define MMT_DEFS_SVH
`define MMT_OFS_CTRL   8'h00
`define MMT_OFS_A_CNT  8'h04
`define MMT_OFS_B_CNT  8'h08
`define MMT_OFS_B_RLD  8'h0C
`define MMT_OFS_STS    8'h10
`define MMT_OFS_MASK   8'h14
`define MMT_CTRL_W     10
`define MMT_CTRL_RST   10'h000
`define MMT_STS_A_REQ  0
`define MMT_STS_B_REQ  1
`define MMT_STS_B_OVF  2
`define MMT_STS_W      3
`define MMT_STS_RST    3'h0
`define MMT_CNT_RST    16'h0000
`define MMT_ALL_ONES   16'hFFFF
`define MMT_ALL_ZEROS  16'h0000
`define MMT_PRESCALE   4
`endif

//--- src/mmt_pkg.sv
package mmt_pkg;
    typedef enum logic [1:0] {
        MMT_A_TMR = 2'h0,
        MMT_A_EVT = 2'h1,
        MMT_A_ONE = 2'h2,
        MMT_A_PWM = 2'h3
    } mmt_a_mode_e;
    typedef enum logic [1:0] {
        MMT_B_TMR  = 2'h0,
        MMT_B_EVT  = 2'h1,
        MMT_B_MEAS = 2'h2,
        MMT_B_RSV  = 2'h3
    } mmt_b_mode_e;
    // gray along idle -> run -> reload
    typedef enum logic [1:0] {
        MMT_IDLE = 2'h0,
        MMT_RUN  = 2'h1,
        MMT_RLD  = 2'h3
    } mmt_st_e;
    // control register, msb first
    typedef struct packed {
        logic        b_msel;
        mmt_b_mode_e b_mode;
        logic        a_ext;
        logic        a_free;
        logic        a_up;
        mmt_a_mode_e a_mode;
        logic        b_start;
        logic        a_start;
    } mmt_ctrl_s;
endpackage

//--- src/mmt_timer.sv
`timescale 1ns/10ps
`include "mmt_defs.svh"
module mmt_timer #(
    parameter int PRESCALE = `MMT_PRESCALE
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // pins
    input  wire logic        first_timer_trigger_input_i,
    input  wire logic        a_event_i,
    input  wire logic        b_event_i,
    input  wire logic        b_meas_i,
    output logic             first_timer_output_pin_o,
    output logic             irq_o
);
    logic                      ack_r;
    logic                      req;
    logic                      wr;
    mmt_pkg::mmt_ctrl_s        ctrl_r;
    mmt_pkg::mmt_ctrl_s        ctrl_nxt;
    logic [`MMT_STS_W-1:0]     sts_r;
    logic [`MMT_STS_W-1:0]     mask_r;
    logic [`MMT_STS_W-1:0]     sts_set;
    logic [15:0]               a_cnt_r;
    logic [15:0]               a_rld_r;
    logic [15:0]               b_cnt_r;
    logic [15:0]               b_rld_r;
    mmt_pkg::mmt_st_e          a_st_r;
    mmt_pkg::mmt_st_e          b_st_r;
    logic                      a_run_q;
    logic                      b_run_q;
    logic                      a_irq_p;
    logic                      b_irq_p;
    logic                      b_ovf_p;
    logic                      a_trig_r;
    logic                      a_rt_r;
    logic                      out_r;
    logic                      b_first_r;
    logic                      trg_q;
    logic                      aev_q;
    logic                      bev_q;
    logic                      bms_q;
    logic [15:0]               pre_r;
    logic                      tick;
    logic                      a_stop;
    logic                      a_go;
    logic                      a_ev;
    logic                      b_ev;
    logic                      b_edge;
    logic                      a_mch;
    logic                      b_mch;
    logic [31:0]               wmask;

    // byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // bus handshake: ack one cycle after request, write on the ack edge
    assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
    assign wb_ack_o = ack_r;
    assign wmask    = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // read data sampled at request, held for the ack cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req) begin
            case (wb_adr_i)
                `MMT_OFS_CTRL:  wb_dat_o <= {22'h00_0000, ctrl_r};
                `MMT_OFS_A_CNT: wb_dat_o <= {16'h0000, a_cnt_r};
                `MMT_OFS_B_CNT: wb_dat_o <= {16'h0000, b_cnt_r};
                `MMT_OFS_B_RLD: wb_dat_o <= {16'h0000, b_rld_r};
                `MMT_OFS_STS:   wb_dat_o <= {29'h0000_0000, sts_r};
                `MMT_OFS_MASK:  wb_dat_o <= {29'h0000_0000, mask_r};
                default:        wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // control register and mode-change detection
    assign ctrl_nxt = mmt_pkg::mmt_ctrl_s'(
        merge({22'h00_0000, ctrl_r}, wb_dat_i, wb_sel_i) & 32'h0000_03FF);
    assign a_mch = wr && wb_adr_i == `MMT_OFS_CTRL
                && (ctrl_r.a_mode == mmt_pkg::MMT_A_TMR || ctrl_r.a_mode == mmt_pkg::MMT_A_EVT)
                && (ctrl_nxt.a_mode == mmt_pkg::MMT_A_ONE
                    || ctrl_nxt.a_mode == mmt_pkg::MMT_A_PWM);
    assign b_mch = wr && wb_adr_i == `MMT_OFS_CTRL && ctrl_r.b_start
                && ctrl_r.b_mode[1] && ctrl_nxt.b_msel != ctrl_r.b_msel;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= mmt_pkg::mmt_ctrl_s'(`MMT_CTRL_RST);
        end else if (wr && wb_adr_i == `MMT_OFS_CTRL) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // sticky status, set wins over write-one-to-clear; mask register
    always_comb begin
        sts_set = '0;
        sts_set[`MMT_STS_A_REQ] = a_irq_p | a_mch;
        sts_set[`MMT_STS_B_REQ] = b_irq_p | b_mch;
        sts_set[`MMT_STS_B_OVF] = b_ovf_p;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sts_r  <= `MMT_STS_RST;
            mask_r <= `MMT_STS_RST;
        end else begin
            if (wr && wb_adr_i == `MMT_OFS_STS) begin
                sts_r <= (sts_r & ~wmask[`MMT_STS_W-1:0]) | sts_set;
            end else begin
                sts_r <= sts_r | sts_set;
            end
            if (wr && wb_adr_i == `MMT_OFS_MASK) begin
                mask_r <= wmask[`MMT_STS_W-1:0];
            end
        end
    end
    assign irq_o = |(sts_r & mask_r);

    // count-source prescaler and input edge history
    assign tick = (pre_r == 16'(PRESCALE - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_r   <= 16'h0000;
            a_run_q <= 1'b0;
            b_run_q <= 1'b0;
            trg_q   <= 1'b0;
            aev_q   <= 1'b0;
            bev_q   <= 1'b0;
            bms_q   <= 1'b0;
        end else begin
            pre_r   <= tick ? 16'h0000 : pre_r + 16'h0001;
            a_run_q <= ctrl_r.a_start;
            b_run_q <= ctrl_r.b_start;
            trg_q   <= first_timer_trigger_input_i;
            aev_q   <= a_event_i;
            bev_q   <= b_event_i;
            bms_q   <= b_meas_i;
        end
    end
    assign a_stop = a_run_q & ~ctrl_r.a_start;
    assign a_go   = ~a_run_q & ctrl_r.a_start;
    assign a_ev   = ctrl_r.a_mode == mmt_pkg::MMT_A_EVT ? (a_event_i & ~aev_q) : tick;
    assign b_ev   = ctrl_r.b_mode == mmt_pkg::MMT_B_EVT ? (b_event_i & ~bev_q) : tick;
    assign b_edge = ctrl_r.b_msel ? (b_meas_i ^ bms_q) : (b_meas_i & ~bms_q);

    // first timer reload register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_rld_r <= `MMT_CNT_RST;
        end else if (wr && wb_adr_i == `MMT_OFS_A_CNT) begin
            a_rld_r <= 16'(merge({16'h0000, a_rld_r}, wb_dat_i, wb_sel_i));
        end
    end

    // one-shot trigger latch, set wins so a trigger is never lost when every clock ticks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_trig_r <= 1'b0;
        end else if (ctrl_r.a_start && (ctrl_r.a_ext ? (first_timer_trigger_input_i & ~trg_q)
                                                   : a_go)) begin
            a_trig_r <= 1'b1;
        end else if (tick) begin
            a_trig_r <= 1'b0;
        end
    end

    // first timer counter, output and request pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_cnt_r <= `MMT_CNT_RST;
            a_st_r  <= mmt_pkg::MMT_IDLE;
            out_r   <= 1'b0;
            a_rt_r  <= 1'b0;
            a_irq_p <= 1'b0;
        end else begin
            a_irq_p <= 1'b0;
            if (wr && wb_adr_i == `MMT_OFS_A_CNT && !ctrl_r.a_start) begin
                a_cnt_r <= wb_dat_i[15:0];
            end else if (a_st_r == mmt_pkg::MMT_RLD) begin
                a_cnt_r <= a_rld_r;
                a_st_r  <= mmt_pkg::MMT_RUN;
            end else if (ctrl_r.a_mode == mmt_pkg::MMT_A_ONE
                         || ctrl_r.a_mode == mmt_pkg::MMT_A_PWM) begin
                if (a_stop && a_st_r != mmt_pkg::MMT_IDLE) begin
                    a_st_r <= mmt_pkg::MMT_IDLE;
                    out_r  <= 1'b0;
                    a_irq_p <= out_r || ctrl_r.a_mode == mmt_pkg::MMT_A_ONE;
                    if (ctrl_r.a_mode == mmt_pkg::MMT_A_ONE) begin
                        a_cnt_r <= a_rld_r;
                    end
                end else if (tick && a_trig_r && a_st_r == mmt_pkg::MMT_IDLE) begin
                    out_r   <= 1'b1;
                    a_cnt_r <= a_rld_r;
                    a_st_r  <= mmt_pkg::MMT_RUN;
                end else if (tick && a_st_r == mmt_pkg::MMT_RUN) begin
                    a_rt_r <= a_trig_r && ctrl_r.a_mode == mmt_pkg::MMT_A_ONE;
                    if (a_rt_r) begin
                        a_cnt_r <= a_rld_r;
                    end else if (a_cnt_r != `MMT_ALL_ZEROS || a_trig_r) begin
                        a_cnt_r <= a_cnt_r - 16'h0001;
                    end else if (ctrl_r.a_mode == mmt_pkg::MMT_A_ONE) begin
                        out_r   <= 1'b0;
                        a_irq_p <= 1'b1;
                        a_cnt_r <= a_rld_r;
                        a_st_r  <= mmt_pkg::MMT_IDLE;
                    end else begin
                        out_r   <= ~out_r;
                        a_irq_p <= out_r;
                        a_cnt_r <= out_r ? ~a_rld_r : a_rld_r;
                    end
                end
            end else if (ctrl_r.a_start && a_ev) begin
                a_st_r <= mmt_pkg::MMT_RUN;
                if (ctrl_r.a_mode == mmt_pkg::MMT_A_EVT && ctrl_r.a_up) begin
                    a_cnt_r <= a_cnt_r + 16'h0001;
                    if (a_cnt_r == `MMT_ALL_ONES) begin
                        a_irq_p <= 1'b1;
                        a_cnt_r <= `MMT_ALL_ZEROS;
                        a_st_r  <= ctrl_r.a_free ? mmt_pkg::MMT_RUN : mmt_pkg::MMT_RLD;
                    end
                end else begin
                    a_cnt_r <= a_cnt_r - 16'h0001;
                    if (a_cnt_r == `MMT_ALL_ZEROS) begin
                        a_irq_p <= 1'b1;
                        a_cnt_r <= `MMT_ALL_ONES;
                        a_st_r  <= (ctrl_r.a_mode == mmt_pkg::MMT_A_EVT && ctrl_r.a_free)
                                   ? mmt_pkg::MMT_RUN : mmt_pkg::MMT_RLD;
                    end
                end
            end else if (!ctrl_r.a_start) begin
                a_st_r <= mmt_pkg::MMT_IDLE;
                out_r  <= 1'b0;
            end
        end
    end
    assign first_timer_output_pin_o = out_r;

    // second timer: timer, event count and pulse measurement
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            b_cnt_r   <= `MMT_CNT_RST;
            b_rld_r   <= `MMT_CNT_RST;
            b_st_r    <= mmt_pkg::MMT_IDLE;
            b_first_r <= 1'b0;
            b_irq_p   <= 1'b0;
            b_ovf_p   <= 1'b0;
        end else begin
            b_irq_p <= 1'b0;
            b_ovf_p <= 1'b0;
            if (wr && wb_adr_i == `MMT_OFS_B_CNT) begin
                b_rld_r <= wb_dat_i[15:0];
                if (!ctrl_r.b_start) begin
                    b_cnt_r <= wb_dat_i[15:0];
                end
            end else if (ctrl_r.b_mode[1]) begin
                if (!b_run_q && ctrl_r.b_start) begin
                    b_first_r <= 1'b1;
                end else if (ctrl_r.b_start && b_edge) begin
                    b_rld_r   <= b_cnt_r;
                    b_cnt_r   <= `MMT_ALL_ZEROS;
                    b_first_r <= 1'b0;
                    b_irq_p   <= ~b_first_r;
                end else if (ctrl_r.b_start && tick) begin
                    b_cnt_r <= b_cnt_r + 16'h0001;
                    if (b_cnt_r == `MMT_ALL_ONES) begin
                        b_ovf_p <= 1'b1;
                        b_irq_p <= 1'b1;
                    end
                end
            end else if (b_st_r == mmt_pkg::MMT_RLD) begin
                b_cnt_r <= b_rld_r;
                b_st_r  <= mmt_pkg::MMT_RUN;
            end else if (ctrl_r.b_start && b_ev) begin
                b_st_r <= mmt_pkg::MMT_RUN;
                if (b_cnt_r == `MMT_ALL_ZEROS) begin
                    b_cnt_r <= `MMT_ALL_ONES;
                    b_irq_p <= 1'b1;
                    b_st_r  <= mmt_pkg::MMT_RLD;
                end else begin
                    b_cnt_r <= b_cnt_r - 16'h0001;
                end
            end
        end
    end

    a_reload_ones: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_r.a_mode == mmt_pkg::MMT_A_TMR && ctrl_r.a_start && tick && a_cnt_r == 16'h0000
         && a_st_r != mmt_pkg::MMT_RLD && !wr)
        |=> a_cnt_r == 16'hFFFF ##1 a_cnt_r == a_rld_r)
        else $error("timer reload read not all ones");
    a_evt_ovf_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_r.a_mode == mmt_pkg::MMT_A_EVT && ctrl_r.a_up && !ctrl_r.a_free && ctrl_r.a_start
         && a_ev && a_cnt_r == 16'hFFFF && a_st_r != mmt_pkg::MMT_RLD && !wr)
        |=> a_cnt_r == 16'h0000 && a_st_r == mmt_pkg::MMT_RLD)
        else $error("overflow reload read not zero");
    a_halt_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && wb_adr_i == 8'h04 && !ctrl_r.a_start && wb_sel_i == 4'hF)
        |=> a_cnt_r == $past(wb_dat_i[15:0]))
        else $error("halted write not read back");
    a_os_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_r.a_mode == mmt_pkg::MMT_A_ONE && a_stop && a_st_r == mmt_pkg::MMT_RUN && !wr)
        |=> !first_timer_output_pin_o && a_cnt_r == $past(a_rld_r) ##1 sts_r[0])
        else $error("one-shot stop misbehaved");
    a_out_sync: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(first_timer_output_pin_o) |-> $past(tick))
        else $error("output rose off a tick");
    a_mode_req: assert property (@(posedge clk_i) disable iff (rst_i)
        a_mch |=> sts_r[0])
        else $error("mode entry did not request");
    a_pwm_low_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_r.a_mode == mmt_pkg::MMT_A_PWM && a_stop && a_st_r == mmt_pkg::MMT_RUN && !out_r
         && !wr) |=> !out_r && !a_irq_p)
        else $error("pwm low stop raised request");
    a_msel_req: assert property (@(posedge clk_i) disable iff (rst_i)
        b_mch |=> sts_r[1])
        else $error("select change did not request");
    a_first_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_r.b_mode[1] && b_first_r && ctrl_r.b_start && b_edge && b_run_q && !wr)
        |=> !b_irq_p && b_rld_r == $past(b_cnt_r))
        else $error("first edge raised request");
    c_os_run: cover property (@(posedge clk_i) $rose(first_timer_output_pin_o)
        && ctrl_r.a_mode == mmt_pkg::MMT_A_ONE);
    c_pwm_fall: cover property (@(posedge clk_i) a_irq_p && ctrl_r.a_mode == mmt_pkg::MMT_A_PWM);
    c_meas_cap: cover property (@(posedge clk_i) b_irq_p && ctrl_r.b_mode[1]);
    c_irq: cover property (@(posedge clk_i) irq_o);
endmodule // mmt_timer

//--- tb/mmt_pin_model.sv
`timescale 1ns/10ps
module mmt_pin_model #(
    parameter int PRESCALE = 1
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // requests from the bench
    input  wire logic trig_req_i,
    input  wire logic ev_req_i,
    input  wire logic meas_req_i,
    // pins toward the timer
    output logic      trig_o,
    output logic      a_ev_o,
    output logic      b_ev_o,
    output logic      meas_o
);
    logic [7:0] gap_r;

    // one-clock trigger pulse, dropped when too close to the last one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_o <= 1'b0;
            gap_r  <= 8'hFF;
        end else if (trig_req_i && gap_r > 8'(PRESCALE)) begin
            trig_o <= 1'b1;
            gap_r  <= 8'h00;
        end else begin
            trig_o <= 1'b0;
            gap_r  <= (gap_r == 8'hFF) ? gap_r : gap_r + 8'h01;
        end
    end

    // event pulses follow the request, measurement line toggles per request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_ev_o <= 1'b0;
            b_ev_o <= 1'b0;
            meas_o <= 1'b0;
        end else begin
            a_ev_o <= ev_req_i;
            b_ev_o <= ev_req_i;
            meas_o <= meas_o ^ meas_req_i;
        end
    end
endmodule // mmt_pin_model

//--- tb/multi_mode_timer_unit_tb.sv
`timescale 1ns/10ps
module multi_mode_timer_unit_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic        ack, pin, irq, trig, aev, bev, meas;
    logic        trig_req = 1'b0, ev_req = 1'b0, meas_req = 1'b0;
    int          err_count = 0, samples_checked = 0;
    typedef struct { logic [7:0] a; logic [31:0] w; logic [31:0] e; } mmt_row_s;
    mmt_row_s rows [5] = '{'{8'h04, 32'h0000_1234, 32'h0000_1234},
                           '{8'h08, 32'hFFFF_5A5A, 32'h0000_5A5A},
                           '{8'h14, 32'h0000_0007, 32'h0000_0007},
                           '{8'h0C, 32'h0000_0000, 32'h0000_5A5A},
                           '{8'h20, 32'h0000_00FF, 32'h0000_0000}};

    always #50 clk_i = ~clk_i;

    mmt_timer #(.PRESCALE(1)) u_mmt_timer (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .first_timer_trigger_input_i(trig), .a_event_i(aev), .b_event_i(bev),
        .b_meas_i(meas), .first_timer_output_pin_o(pin), .irq_o(irq));

    mmt_pin_model #(.PRESCALE(1)) u_mmt_pin_model (
        .clk_i(clk_i), .rst_i(rst_i), .trig_req_i(trig_req), .ev_req_i(ev_req),
        .meas_req_i(meas_req), .trig_o(trig), .a_ev_o(aev), .b_ev_o(bev), .meas_o(meas));

    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one classic wishbone cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n >= 20) begin
            err_count++;
            tally_and_finish();
        end
    endtask

    // wait with a bound until the output pin reaches a level
    task automatic wait_pin(input logic lvl);
        int n;
        for (n = 0; n < 200 && pin !== lvl; n++) @(posedge clk_i);
        if (n >= 200) begin
            err_count++;
            tally_and_finish();
        end
    endtask

    // counting poll: every read is at or above lo, or at or below hi
    task automatic poll(input logic [7:0] a, input logic [31:0] ctl, input logic [31:0] cnt,
                        input logic [15:0] lo, input logic [15:0] hi);
        xfer(1, a, cnt);
        xfer(1, 8'h00, ctl);
        repeat (12) begin
            ev_req <= 1'b1;
            @(posedge clk_i);
            ev_req <= 1'b0;
            xfer(0, a, 0);
            chk(q[15:0] >= lo || q[15:0] <= hi, 1);
        end
        xfer(1, 8'h00, ctl & 32'h0000_03FC);
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        xfer(0, 8'h10, 0);
        chk({q[2:0], pin, irq}, 0);
        foreach (rows[i]) begin
            xfer(1, rows[i].a, rows[i].w);
            xfer(0, rows[i].a, 0);
            chk(q, rows[i].e);
        end
        $display("test register table done");
        xfer(1, 8'h14, 0);
        poll(8'h04, 32'h001, 32'h3, 16'hFFFF, 16'h0003);
        poll(8'h08, 32'h002, 32'h3, 16'hFFFF, 16'h0003);
        poll(8'h08, 32'h082, 32'h3, 16'hFFFF, 16'h0003);
        poll(8'h04, 32'h015, 32'hFFFE, 16'hFFFE, 16'h0000);
        $display("test live reads done");
        // one-shot entered from event mode with external trigger
        xfer(1, 8'h00, 32'h048);
        xfer(0, 8'h10, 0);
        chk(q[0], 1);
        xfer(1, 8'h14, 32'h1);
        @(posedge clk_i);
        chk(irq, 1);
        xfer(1, 8'h10, 32'h1);
        @(posedge clk_i);
        chk(irq, 0);
        xfer(1, 8'h04, 32'h0100);
        xfer(1, 8'h00, 32'h049);
        trig_req <= 1'b1;
        @(posedge clk_i);
        trig_req <= 1'b0;
        wait_pin(1);
        xfer(1, 8'h00, 32'h048);
        repeat (2) @(posedge clk_i);
        chk(pin, 0);
        xfer(0, 8'h10, 0);
        chk(q[0], 1);
        xfer(0, 8'h04, 0);
        chk(q, 32'h0100);
        // retrigger mid-count stretches the pulse past its plain length
        xfer(1, 8'h04, 32'h0010);
        xfer(1, 8'h00, 32'h049);
        trig_req <= 1'b1;
        @(posedge clk_i);
        trig_req <= 1'b0;
        wait_pin(1);
        repeat (4) @(posedge clk_i);
        trig_req <= 1'b1;
        @(posedge clk_i);
        trig_req <= 1'b0;
        repeat (16) @(posedge clk_i);
        chk(pin, 1);
        wait_pin(0);
        xfer(1, 8'h00, 32'h048);
        $display("test one-shot done");
        // pwm entered from event mode, stopped while low and while high
        xfer(1, 8'h00, 32'h004);
        xfer(1, 8'h10, 32'h7);
        xfer(1, 8'h00, 32'h00C);
        xfer(0, 8'h10, 0);
        chk(q[0], 1);
        xfer(1, 8'h04, 32'h0008);
        xfer(1, 8'h00, 32'h00D);
        wait_pin(1);
        wait_pin(0);
        xfer(1, 8'h10, 32'h1);
        xfer(1, 8'h00, 32'h00C);
        xfer(0, 8'h10, 0);
        chk({pin, q[0]}, 0);
        xfer(1, 8'h00, 32'h00D);
        wait_pin(1);
        xfer(1, 8'h00, 32'h00C);
        repeat (2) @(posedge clk_i);
        chk(pin, 0);
        xfer(0, 8'h10, 0);
        chk(q[0], 1);
        $display("test pwm done");
        // measurement: first edge quiet, select change requests
        xfer(1, 8'h00, 32'h102);
        xfer(1, 8'h10, 32'h7);
        meas_req <= 1'b1;
        @(posedge clk_i);
        meas_req <= 1'b0;
        repeat (4) @(posedge clk_i);
        xfer(0, 8'h10, 0);
        chk(q[1], 0);
        xfer(1, 8'h00, 32'h302);
        xfer(0, 8'h10, 0);
        chk(q[1], 1);
        $display("test measurement done");
        // reset in mid-run clears control, status and pins
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        xfer(0, 8'h00, 0);
        chk(q, 0);
        xfer(0, 8'h10, 0);
        chk({q[2:0], pin, irq}, 0);
        $display("test reset done");
        tally_and_finish();
    end
endmodule // multi_mode_timer_unit_tb
